// ---- edge_if.sv ----
`timescale 1ns/1ns
interface edge_if;
  logic level;
  logic rise;
  modport producer (output level, output rise);
  modport consumer (input  level, input  rise);
endinterface

// ---- multi_card_trigger_sync.sv ----
`timescale 1ns/1ns
// Summary of operation
// - one master drives, up to three slaves
// - master forwards onboard timebase to shared line
// - external sine timebase never forwarded
// - receiver uses shared timebase for acquisition
// - raw trigger output carries own trigger
// - raw trigger input rising edge triggers
// - dedicated source choice selects raw line
// - clocked output is raw output registered once
// - clocked trigger edge compensated one timebase cycle
// - start output carries own operation start except in post mode
// - shared start edge replaces software start
// - clocked choice selects clocked trigger, and start except in post mode
// - lines driven only when output enabled
// - clocked trigger seen on same timebase edge
// - shared start aligns first stored sample
// - raw path has no cycle alignment
// - pre mode keeps samples before trigger
// - middle mode stores programmed before/after counts
module multi_card_trigger_sync #(
  parameter int CNT_W = sync_pkg::CNT_W_DEFAULT
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_tb_master,
  input  wire logic                  i_tb_receive,
  input  wire logic                  i_use_ext_sine,
  input  wire sync_pkg::trig_src_t   i_trig_src,
  input  wire sync_pkg::acq_mode_t   i_mode,
  input  wire logic                  i_ignore_early_trig,
  input  wire logic [CNT_W-1:0]      i_pre_count,
  input  wire logic [CNT_W-1:0]      i_post_count,
  input  wire logic                  i_raw_trig_out_en,
  input  wire logic                  i_clk_trig_out_en,
  input  wire logic                  i_start_out_en,
  input  wire logic                  i_sw_start,
  input  wire logic                  i_sw_trigger,
  input  wire logic                  i_analog_trigger,
  input  wire logic                  i_digital_trigger,
  input  wire logic                  i_onboard_timebase,
  input  wire logic                  i_ext_sine_timebase,
  input  wire logic                  i_shared_timebase,
  output logic                       o_shared_timebase,
  output logic                       o_shared_timebase_oe,
  input  wire logic                  i_shared_raw_trigger,
  output logic                       o_shared_raw_trigger,
  output logic                       o_shared_raw_trigger_oe,
  input  wire logic                  i_shared_clocked_trigger,
  output logic                       o_shared_clocked_trigger,
  output logic                       o_shared_clocked_trigger_oe,
  input  wire logic                  i_shared_op_start,
  output logic                       o_shared_op_start,
  output logic                       o_shared_op_start_oe,
  output logic                       o_tick,
  output logic                       o_store,
  output logic                       o_busy,
  output logic                       o_done,
  output logic [CNT_W-1:0]           o_pre_stored
);
  import sync_pkg::*;

  edge_if onb_e ();
  edge_if ext_e ();
  edge_if stb_e ();
  edge_if raw_e ();
  edge_if ckt_e ();
  edge_if sta_e ();

  // every timebase and shared-line pin passes two flops before any logic looks at it
  pin_sync_edge u_onb (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_onboard_timebase), .edge_out(onb_e));
  pin_sync_edge u_ext (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_ext_sine_timebase), .edge_out(ext_e));
  pin_sync_edge u_stb (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_shared_timebase), .edge_out(stb_e));
  pin_sync_edge u_raw (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_shared_raw_trigger), .edge_out(raw_e));
  pin_sync_edge u_ckt (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_shared_clocked_trigger), .edge_out(ckt_e));
  pin_sync_edge u_sta (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_async(i_shared_op_start), .edge_out(sta_e));

  acq_state_t            state_reg;
  acq_state_t            state_next;
  logic [CNT_W-1:0]      pre_cnt_reg;
  logic [CNT_W-1:0]      pre_cnt_next;
  logic [CNT_W-1:0]      post_left_reg;
  logic [CNT_W-1:0]      post_left_next;
  logic [TICK_CNT_W-1:0] raw_cnt_reg;
  logic [TICK_CNT_W-1:0] raw_cnt_next;
  logic [TICK_CNT_W-1:0] sta_cnt_reg;
  logic [TICK_CNT_W-1:0] sta_cnt_next;
  logic                  ckt_prev_reg;
  logic                  ckt_prev_next;
  logic                  sta_prev_reg;
  logic                  sta_prev_next;
  logic                  raw_out_next;
  logic                  ckt_out_next;
  logic                  sta_out_next;
  logic                  store_next;

  logic                  tick;
  logic                  clocked_src;
  logic                  ckt_rise_tb;
  logic                  sta_rise_tb;
  logic                  start_evt;
  logic                  trig_evt;
  logic                  storing;
  logic                  trig_ok;
  logic                  own_trig;
  logic                  own_start;

  always_comb begin
    // shared line replaces onboard source; raw path stays unaligned
    if (i_tb_receive) begin
      tick = stb_e.rise;
    end else if (i_use_ext_sine) begin
      tick = ext_e.rise;
    end else begin
      tick = onb_e.rise;
    end
    clocked_src = (i_trig_src == TRIG_SRC_SYNC_CLOCKED);
    // sampled only on the active timebase edge so all cards agree
    ckt_rise_tb = tick & ckt_e.level & ~ckt_prev_reg;
    sta_rise_tb = tick & sta_e.level & ~sta_prev_reg;
    ckt_prev_next = tick ? ckt_e.level : ckt_prev_reg;
    sta_prev_next = tick ? sta_e.level : sta_prev_reg;
    if (clocked_src && (i_mode != MODE_POST)) begin
      start_evt = sta_rise_tb;
    end else begin
      start_evt = i_sw_start;
    end
    case (i_trig_src)
      TRIG_SRC_SOFTWARE:     trig_evt = i_sw_trigger;
      TRIG_SRC_ANALOG:       trig_evt = i_analog_trigger;
      TRIG_SRC_DIGITAL:      trig_evt = i_digital_trigger;
      TRIG_SRC_SYNC_RAW:     trig_evt = raw_e.rise;
      TRIG_SRC_SYNC_CLOCKED: trig_evt = ckt_rise_tb;
      default:               trig_evt = 1'b0;
    endcase
  end

  always_comb begin
    state_next     = state_reg;
    pre_cnt_next   = pre_cnt_reg;
    post_left_next = post_left_reg;
    storing        = 1'b0;
    own_trig       = 1'b0;
    own_start      = 1'b0;
    trig_ok        = ~(i_ignore_early_trig && (pre_cnt_reg < i_pre_count));
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (start_evt) begin
          state_next     = ST_PRE;
          pre_cnt_next   = '0;
          post_left_next = i_post_count;
          own_start      = (i_mode != MODE_POST);
        end
      end
      ST_PRE: begin
        // buffer wraps, so only the newest pre-count samples survive
        if (tick && (i_mode != MODE_POST)) begin
          storing = 1'b1;
          if (pre_cnt_reg < i_pre_count) begin
            pre_cnt_next = pre_cnt_reg + 1'b1;
          end
        end
        if (trig_evt && trig_ok) begin
          own_trig = 1'b1;
          if (clocked_src) begin
            // edge arrived one timebase cycle late: drop the extra sample
            if (pre_cnt_next != '0) begin
              pre_cnt_next = pre_cnt_next - 1'b1;
            end
            post_left_next = (i_post_count != '0) ? i_post_count - 1'b1 : '0;
          end
          if (i_mode == MODE_PRE) begin
            state_next = ST_DONE;
          end else if (post_left_next == '0) begin
            state_next = ST_DONE;
          end else begin
            state_next = ST_POST;
          end
        end
      end
      ST_POST: begin
        if (post_left_reg == '0) begin
          state_next = ST_DONE;
        end else if (tick) begin
          storing        = 1'b1;
          post_left_next = post_left_reg - 1'b1;
          if (post_left_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            state_next = ST_DONE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    store_next = storing;
  end

  // outgoing pulses last a few timebase ticks so slower samplers catch them
  always_comb begin
    raw_cnt_next = raw_cnt_reg;
    sta_cnt_next = sta_cnt_reg;
    if (own_trig) begin
      raw_cnt_next = PULSE_TICKS;
    end else if (tick && (raw_cnt_reg != '0)) begin
      raw_cnt_next = raw_cnt_reg - 1'b1;
    end
    if (own_start) begin
      sta_cnt_next = PULSE_TICKS;
    end else if (tick && (sta_cnt_reg != '0)) begin
      sta_cnt_next = sta_cnt_reg - 1'b1;
    end
    raw_out_next = (raw_cnt_next != '0);
    sta_out_next = (sta_cnt_next != '0);
    ckt_out_next = tick ? o_shared_raw_trigger : o_shared_clocked_trigger;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (i_reset_n == RESET_LOW) begin
      state_reg                   <= ST_IDLE;
      pre_cnt_reg                 <= '0;
      post_left_reg               <= '0;
      raw_cnt_reg                 <= '0;
      sta_cnt_reg                 <= '0;
      ckt_prev_reg                <= 1'b0;
      sta_prev_reg                <= 1'b0;
      o_shared_timebase           <= 1'b0;
      o_shared_timebase_oe        <= 1'b0;
      o_shared_raw_trigger        <= 1'b0;
      o_shared_raw_trigger_oe     <= 1'b0;
      o_shared_clocked_trigger    <= 1'b0;
      o_shared_clocked_trigger_oe <= 1'b0;
      o_shared_op_start           <= 1'b0;
      o_shared_op_start_oe        <= 1'b0;
      o_tick                      <= 1'b0;
      o_store                     <= 1'b0;
      o_busy                      <= 1'b0;
      o_done                      <= 1'b0;
      o_pre_stored                <= '0;
    end else begin
      state_reg                   <= state_next;
      pre_cnt_reg                 <= pre_cnt_next;
      post_left_reg               <= post_left_next;
      raw_cnt_reg                 <= raw_cnt_next;
      sta_cnt_reg                 <= sta_cnt_next;
      ckt_prev_reg                <= ckt_prev_next;
      sta_prev_reg                <= sta_prev_next;
      // only the onboard source is ever forwarded, never the sine input
      o_shared_timebase           <= onb_e.level;
      o_shared_timebase_oe        <= i_tb_master & ~i_tb_receive;
      o_shared_raw_trigger        <= raw_out_next;
      o_shared_raw_trigger_oe     <= i_raw_trig_out_en;
      o_shared_clocked_trigger    <= ckt_out_next;
      o_shared_clocked_trigger_oe <= i_clk_trig_out_en;
      o_shared_op_start           <= sta_out_next;
      o_shared_op_start_oe        <= i_start_out_en;
      o_tick                      <= tick;
      o_store                     <= store_next;
      o_busy                      <= (state_next == ST_PRE) || (state_next == ST_POST);
      o_done                      <= (state_next == ST_DONE);
      o_pre_stored                <= pre_cnt_next;
    end
  end
endmodule

// ---- pin_sync_edge.sv ----
`timescale 1ns/1ns
module pin_sync_edge (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_async,
  edge_if.producer        edge_out
);
  import sync_pkg::*;

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (i_reset_n == RESET_LOW) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign edge_out.level = sync_reg;
  assign edge_out.rise  = sync_reg & ~prev_reg;
endmodule

// ---- sync_assertions.sv ----
`timescale 1ns/1ns
module sync_assertions
  import sync_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEFAULT
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_tb_master,
  input wire logic        i_tb_receive,
  input wire trig_src_t   i_trig_src,
  input wire acq_mode_t   i_mode,
  input wire logic        i_sw_start,
  input wire logic [CNT_W-1:0] i_pre_count,
  input wire logic        i_raw_trig_out_en,
  input wire logic        i_clk_trig_out_en,
  input wire logic        i_start_out_en,
  input wire logic        o_shared_timebase_oe,
  input wire logic        o_shared_raw_trigger,
  input wire logic        o_shared_raw_trigger_oe,
  input wire logic        o_shared_clocked_trigger,
  input wire logic        o_shared_clocked_trigger_oe,
  input wire logic        o_shared_op_start,
  input wire logic        o_shared_op_start_oe,
  input wire logic        o_tick,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [CNT_W-1:0] o_pre_stored
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_TB_OE: assert property (o_shared_timebase_oe == $past(i_tb_master && !i_tb_receive))
    else $error("timebase drive enable wrong");
  AST_RAW_OE: assert property (o_shared_raw_trigger_oe == $past(i_raw_trig_out_en))
    else $error("raw trigger enable wrong");
  AST_CLK_OE: assert property (o_shared_clocked_trigger_oe == $past(i_clk_trig_out_en))
    else $error("clocked trigger enable wrong");
  AST_START_OE: assert property (o_shared_op_start_oe == $past(i_start_out_en))
    else $error("start enable wrong");
  AST_CLK_TRIG: assert property ($changed(o_shared_clocked_trigger) |-> (o_tick || $past(o_tick)) &&
    (o_shared_clocked_trigger == $past(o_shared_raw_trigger) || o_shared_clocked_trigger == $past(o_shared_raw_trigger, 2)))
    else $error("clocked trigger not raw registered at tick");
  AST_PRE_LIMIT: assert property (o_busy && i_mode == MODE_PRE |-> o_pre_stored <= i_pre_count)
    else $error("pre samples beyond count");
  AST_DONE_HOLD: assert property (o_done && !i_sw_start && i_trig_src != TRIG_SRC_SYNC_CLOCKED |=> o_done)
    else $error("done dropped without start");
  AST_START_OUT: assert property ($rose(o_busy) && i_mode != MODE_POST && i_trig_src != TRIG_SRC_SYNC_CLOCKED
    |-> o_shared_op_start) else $error("start output missing");
  AST_RAW_OUT: assert property ($fell(o_busy) && o_done && i_mode == MODE_PRE && i_trig_src != TRIG_SRC_SYNC_CLOCKED
    |-> o_shared_raw_trigger) else $error("raw trigger output missing");
endmodule
bind multi_card_trigger_sync sync_assertions #(.CNT_W(CNT_W)) sync_assertions_inst (.*);

// ---- sync_partner.sv ----
`timescale 1ns/1ns
// master card on the bus; timebase runs free, triggers on request
module sync_partner (
  input  wire logic i_start_req,
  input  wire logic i_trig_req,
  input  wire logic i_clocked,
  output logic      o_timebase,
  output logic      o_raw_trigger,
  output logic      o_clocked_trigger,
  output logic      o_op_start
);
  initial begin
    o_timebase = 1'b0;
    o_raw_trigger = 1'b0;
    o_clocked_trigger = 1'b0;
    o_op_start = 1'b0;
    forever begin
      #62 o_timebase = 1'b1;
      #63 o_timebase = 1'b0;
    end
  end
  always @(posedge i_start_req) begin
    @(posedge o_timebase);
    o_op_start = 1'b1;
    repeat (2) @(posedge o_timebase);
    o_op_start = 1'b0;
  end
  always @(posedge i_trig_req) begin
    if (!i_clocked) begin
      o_raw_trigger = 1'b1;
      #200 o_raw_trigger = 1'b0;
    end else begin
      @(posedge o_timebase);
      o_raw_trigger = 1'b1;
      @(posedge o_timebase);
      o_clocked_trigger = 1'b1;
      @(posedge o_timebase);
      o_raw_trigger = 1'b0;
      @(posedge o_timebase);
      o_clocked_trigger = 1'b0;
    end
  end
endmodule

// ---- sync_pkg.sv ----
package sync_pkg;

  localparam int CNT_W_DEFAULT = 16;
  localparam int TICK_CNT_W = 3;
  localparam logic [TICK_CNT_W-1:0] PULSE_TICKS = 3'h2;
  localparam logic RESET_LOW = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE  = 4'b0010,
    ST_POST = 4'b0100,
    ST_DONE = 4'b1000
  } acq_state_t;

  typedef enum logic [2:0] {
    TRIG_SRC_SOFTWARE     = 3'h0,
    TRIG_SRC_ANALOG       = 3'h1,
    TRIG_SRC_DIGITAL      = 3'h2,
    TRIG_SRC_SYNC_RAW     = 3'h3,
    TRIG_SRC_SYNC_CLOCKED = 3'h4
  } trig_src_t;

  typedef enum logic [1:0] {
    MODE_POST   = 2'h0,
    MODE_PRE    = 2'h1,
    MODE_MIDDLE = 2'h2
  } acq_mode_t;

endpackage

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import sync_pkg::*;
  logic        clk, rst_n, tb_master, tb_receive, ext_sine, ign, sw_start, sw_trig, an_trig, dig_trig;
  logic        raw_en, ck_en, st_en, onboard, sine, onboard_run, start_req, trig_req, req_clocked, acc;
  logic        tb_o, tb_oe, raw_o, raw_oe, ck_o, ck_oe, st_o, st_oe, tick, store, busy, done;
  logic        p_tb, p_raw, p_ck, p_st;
  logic        prev_raw = 1'b0;
  logic        exp_ck = 1'b0;
  trig_src_t   src;
  acq_mode_t   mode;
  logic [15:0] pre_cnt, post_cnt, pre_stored;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    onboard = 1'b0;
    forever #80 onboard = onboard_run ? ~onboard : 1'b0;
  end
  initial begin
    sine = 1'b0;
    forever #45 sine = ~sine;
  end
  sync_partner sync_partner_inst (.i_start_req(start_req), .i_trig_req(trig_req), .i_clocked(req_clocked),
    .o_timebase(p_tb), .o_raw_trigger(p_raw), .o_clocked_trigger(p_ck), .o_op_start(p_st));
  // our drivers win the wire; the master is kept quiet in output tests
  multi_card_trigger_sync #(.CNT_W(16)) multi_card_trigger_sync_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_tb_master(tb_master), .i_tb_receive(tb_receive),
    .i_use_ext_sine(ext_sine), .i_trig_src(src), .i_mode(mode), .i_ignore_early_trig(ign),
    .i_pre_count(pre_cnt), .i_post_count(post_cnt), .i_raw_trig_out_en(raw_en), .i_clk_trig_out_en(ck_en),
    .i_start_out_en(st_en), .i_sw_start(sw_start), .i_sw_trigger(sw_trig), .i_analog_trigger(an_trig),
    .i_digital_trigger(dig_trig), .i_onboard_timebase(onboard), .i_ext_sine_timebase(sine),
    .i_shared_timebase(tb_oe ? tb_o : p_tb), .o_shared_timebase(tb_o), .o_shared_timebase_oe(tb_oe),
    .i_shared_raw_trigger(raw_oe ? raw_o : p_raw), .o_shared_raw_trigger(raw_o), .o_shared_raw_trigger_oe(raw_oe),
    .i_shared_clocked_trigger(ck_oe ? ck_o : p_ck), .o_shared_clocked_trigger(ck_o),
    .o_shared_clocked_trigger_oe(ck_oe), .i_shared_op_start(st_oe ? st_o : p_st), .o_shared_op_start(st_o),
    .o_shared_op_start_oe(st_oe), .o_tick(tick), .o_store(store), .o_busy(busy), .o_done(done),
    .o_pre_stored(pre_stored));
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // which: 0 sw start, 1 sw trig, 2 analog, 3 digital, 4 partner trigger, 5 partner start
  task automatic pulse(input int which);
    @(posedge clk);
    {start_req, trig_req, dig_trig, an_trig, sw_trig, sw_start} <= 6'h1 << which;
    @(posedge clk);
    {start_req, trig_req, dig_trig, an_trig, sw_trig, sw_start} <= 6'h0;
  endtask
  // clocked line must follow the raw line as it stood before each tick
  always @(negedge clk) begin
    if (tick === 1'b1) exp_ck = prev_raw;
    prev_raw = raw_o;
    if (rst_n === 1'b1) check(16'(ck_o), 16'(exp_ck), "clocked trigger output");
  end
  task automatic sample_tb(input int n);
    acc = 1'b0;
    repeat (n) begin
      @(negedge clk);
      acc = acc | tb_o;
    end
  endtask
  task automatic acquire(input acq_mode_t m, input trig_src_t s, input logic early);
    int n;
    n = 0;
    @(posedge clk);
    mode <= m;
    src <= s;
    ign <= !early && (m != MODE_POST); // post mode stores nothing before the trigger, so no early guard
    req_clocked <= (s == TRIG_SRC_SYNC_CLOCKED);
    pre_cnt <= 16'(8 + $urandom % 8); // more than the ticks before the early trigger
    post_cnt <= 16'(1 + $urandom % 6);
    pulse((s == TRIG_SRC_SYNC_CLOCKED) ? 5 : 0);
    @(negedge clk);
    if (s != TRIG_SRC_SYNC_CLOCKED) check(16'(st_o), 16'(m != MODE_POST), "start output");
    repeat (40) @(posedge clk);
    if (!early && m != MODE_POST) begin
      pulse(1); // early or foreign trigger must be refused
      repeat (4) @(negedge clk);
      check(16'(busy), 16'h1, "early trigger taken");
    end
    if (!early) repeat ((pre_cnt + 3) * 15) @(posedge clk);
    repeat (20) begin
      @(negedge clk);
      if (tick === 1'b1) break;
    end
    case (s)
      TRIG_SRC_SOFTWARE: pulse(1);
      TRIG_SRC_ANALOG:   pulse(2);
      TRIG_SRC_DIGITAL:  pulse(3);
      default:           pulse(4);
    endcase
    repeat (300) begin
      @(negedge clk);
      if (store === 1'b1) n = n + 1;
      if (done === 1'b1) break;
    end
    check(16'(done), 16'h1, "acquisition not done");
    if (m == MODE_PRE) check(16'(raw_o), 16'h1, "raw output missing");
    if (m == MODE_PRE && early) check(16'(pre_stored < pre_cnt), 16'h1, "early stop count");
    else if (m == MODE_PRE) check(pre_stored, pre_cnt - 16'(s == TRIG_SRC_SYNC_CLOCKED), "pre count");
    else begin
      check(16'(n), post_cnt, "post samples");
      check(pre_stored, (m == MODE_POST) ? 16'h0 : pre_cnt, "pre samples");
    end
    $display("test mode %0d src %0d early %0b finished", m, s, early);
  endtask
  initial begin
    {rst_n, tb_master, tb_receive, ext_sine, ign, sw_start, sw_trig, an_trig, dig_trig} = '0;
    {raw_en, ck_en, st_en, onboard_run, start_req, trig_req, req_clocked} = '0;
    src = TRIG_SRC_SOFTWARE;
    mode = MODE_PRE;
    pre_cnt = 16'h2;
    post_cnt = 16'h1;
    void'($urandom(32'h2c647de7));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tb_master <= 1'b1;
    ext_sine <= 1'b1;
    sample_tb(60);
    check(16'(tb_oe), 16'h1, "timebase not driven");
    check(16'(acc), 16'h0, "sine forwarded");
    onboard_run = 1'b1;
    sample_tb(60);
    check(16'(acc), 16'h1, "onboard not forwarded");
    @(posedge clk);
    onboard_run <= 1'b0;
    tb_master <= 1'b0;
    tb_receive <= 1'b1; // ticks now only from the shared line
    ext_sine <= 1'b0;
    for (int s = 0; s < 5; s++) acquire(MODE_PRE, trig_src_t'(s), 1'b0);
    acquire(MODE_PRE, TRIG_SRC_SOFTWARE, 1'b1);
    acquire(MODE_MIDDLE, TRIG_SRC_SOFTWARE, 1'b0);
    acquire(MODE_POST, TRIG_SRC_SOFTWARE, 1'b0);
    @(posedge clk);
    {raw_en, ck_en, st_en} <= 3'b111;
    repeat (2) acquire(($urandom % 2) ? MODE_MIDDLE : MODE_PRE, TRIG_SRC_SOFTWARE, 1'b0);
    check(16'({raw_oe, ck_oe, st_oe}), 16'h7, "outputs not driven");
    @(posedge clk);
    {raw_en, ck_en, st_en} <= 3'b000;
    repeat (3) @(negedge clk);
    check(16'({raw_oe, ck_oe, st_oe, tb_oe}), 16'h0, "lines not released");
    finish_test();
  end
endmodule
